//--- verif/lgde_mem_model.sv
// byte-wide program and data memory standing beside the load unit
`default_nettype none
`timescale 1ns/1ns
module lgde_mem_model (
  input  wire logic        clk_in,
  input  wire logic [14:0] addr_in,
  input  wire logic        rd_in,
  output logic [7:0]       data_out
);
  // whole 15-bit space, filled by the bench before each run
  logic [7:0] mem [0:32767];

  initial data_out = 8'h00;

  // data follows the address one clock later, well inside the cycle;
  // when not read the bus toggles, so a stale byte is never mistaken
  always @(posedge clk_in) begin
    if (rd_in) begin
      data_out <= mem[addr_in];
    end else begin
      data_out <= ~data_out;
    end
  end
endmodule
`default_nettype wire

//--- verif/load_group_decode_execute_test.sv
// self-checking bench for the load group sequencer
`default_nettype none
`timescale 1ns/1ns
`include "lgde_map.svh"
module load_group_decode_execute_test;
  logic        clk_sys_in = 1'b0;
  logic        nrst_in    = 1'b0;
  logic [7:0]  wb_adr     = 8'h00;
  logic [31:0] wb_dat_w   = 32'h0;
  logic        wb_we      = 1'b0;
  logic [3:0]  wb_sel     = 4'hf;
  logic        wb_cyc     = 1'b0;
  logic        wb_stb     = 1'b0;
  logic [31:0] wb_dat_r;
  logic        wb_ack;
  logic [14:0] mem_addr;
  logic        mem_rd;
  logic [7:0]  mem_data;
  int          n_fail     = 0;
  int          n_tests    = 0;
  int          cyc_n      = 1;
  int          fetch_t [32];
  logic [7:0]  img [0:32767];
  // program image: imm, reg, nop, alias, rel, abs, pre-inc, pre-dec,
  // indirect post-indexed, halt
  localparam logic [7:0] PROG [20] = '{8'h05, 8'h00, 8'h01, 8'hc0,
    8'h60, 8'h0a, 8'h3f, 8'h0f, 8'h01, 8'h00, 8'h0f, 8'h21, 8'h30,
    8'h0d, 8'h41, 8'h20, 8'h0e, 8'he1, 8'h10, 8'h40};
  localparam int OP_AT [10] = '{0, 2, 3, 4, 5, 7, 10, 13, 16, 19};
  localparam int OP_MC [9]  = '{2, 2, 2, 2, 3, 4, 4, 4, 6};

  lgde_core #(.NUM_REGS(4)) lgde_core_i (
    .clk_sys_in   (clk_sys_in),
    .nrst_in      (nrst_in),
    .ce_in        (1'b1),
    .wb_adr_in    (wb_adr),
    .wb_dat_in    (wb_dat_w),
    .wb_dat_out   (wb_dat_r),
    .wb_we_in     (wb_we),
    .wb_sel_in    (wb_sel),
    .wb_cyc_in    (wb_cyc),
    .wb_stb_in    (wb_stb),
    .wb_ack_out   (wb_ack),
    .mem_addr_out (mem_addr),
    .mem_rd_out   (mem_rd),
    .mem_data_in  (mem_data)
  );

  lgde_mem_model lgde_mem_model_i (
    .clk_in   (clk_sys_in),
    .addr_in  (mem_addr),
    .rd_in    (mem_rd),
    .data_out (mem_data)
  );

  // 100 MHz clock
  always #5 clk_sys_in = ~clk_sys_in;

  // first clock of each read cycle below 32 marks an opcode fetch
  always @(posedge clk_sys_in) begin
    cyc_n <= cyc_n + 1;
    if (mem_rd === 1'b1 && mem_addr < 15'd32) begin
      if (fetch_t[mem_addr[4:0]] == 0) fetch_t[mem_addr[4:0]] <= cyc_n;
    end
  end

  // flags expected from a loaded byte
  function automatic logic [1:0] cc_of(input logic [7:0] v);
    if (v == 8'h00) return `LGDE_CC_ZERO;
    return v[7] ? `LGDE_CC_NEG : `LGDE_CC_POS;
  endfunction

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one classic cycle; waits for ack with a bound, takes data at that edge
  task automatic wb_io(input logic we, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_adr   <= a;
    wb_dat_w <= d;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    if (n >= 20) check("wb ack", 32'h0, 32'h1);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // watchdog well beyond three short programs
  initial begin
    repeat (30000) @(posedge clk_sys_in);
    n_fail++;
    finish_test();
  end

  initial begin
    logic [31:0] q;
    logic [7:0]  v1, r0e, r1e, r2e, r3e, rv;
    int          k;
    void'($urandom(53));
    repeat (6) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    // unmapped place: write ignored, reads zero
    wb_io(1'b1, 8'h40, $urandom, q);
    wb_io(1'b0, 8'h40, 32'h0, q);
    check("unmapped", q, 32'h0);
    for (int it = 0; it < 3; it++) begin
      // stop the engine and leave any halt
      wb_io(1'b1, `LGDE_OFF_CTRL, 32'h2, q);
      v1 = (it == 0) ? 8'h00 : 8'($urandom);
      for (int a = 0; a < 32768; a++) img[a] = 8'($urandom);
      // software uses 60 rather than the all-zero code
      // alias byte
      for (int a = 0; a < 20; a++) img[a] = PROG[a];
      img[1] = v1;
      img[15'h110] = 8'ha5;
      img[15'h111] = 8'h50;
      r2e = img[15'h46];
      // zero and negative corner loads on the first two passes
      if (it < 2) img[15'h2550 + r2e] = (it == 0) ? 8'h00 : 8'h80;
      for (int a = 0; a < 32768; a++) lgde_mem_model_i.mem[a] = img[a];
      r1e = v1 - 8'h01;
      r3e = img[15'h100] + 8'h01;
      r0e = img[15'h2550 + r2e];
      for (int a = 0; a < 32; a++) fetch_t[a] = 0;
      for (int r = 0; r < 4; r++) begin
        rv = 8'($urandom);
        wb_io(1'b1, `LGDE_OFF_REGS + 8'(4 * r), {24'h0, rv}, q);
        wb_io(1'b0, `LGDE_OFF_REGS + 8'(4 * r), 32'h0, q);
        check("reg write", q, {24'h0, rv});
      end
      wb_io(1'b1, `LGDE_OFF_PC, 32'h0, q);
      wb_io(1'b1, `LGDE_OFF_CTRL, 32'h1, q);
      k = 0;
      do begin
        wb_io(1'b0, `LGDE_OFF_STAT, 32'h0, q);
        k++;
      end while (q[`LGDE_STAT_HALT] !== 1'b1 && k < 200);
      check("halted", {31'h0, q[`LGDE_STAT_HALT]}, 32'h1);
      check("flags", {30'h0, q[3:2]}, {30'h0, cc_of(r0e)});
      wb_io(1'b0, `LGDE_OFF_REGS, 32'h0, q);
      check("r0", q, {24'h0, r0e});
      wb_io(1'b0, `LGDE_OFF_REGS + 8'h04, 32'h0, q);
      check("r1", q, {24'h0, r1e});
      wb_io(1'b0, `LGDE_OFF_REGS + 8'h08, 32'h0, q);
      check("r2", q, {24'h0, r2e});
      wb_io(1'b0, `LGDE_OFF_REGS + 8'h0c, 32'h0, q);
      check("r3", q, {24'h0, r3e});
      // spacing of opcode fetches gives each instruction's length
      for (int i = 0; i < 9; i++) begin
        k = fetch_t[OP_AT[i + 1]] - fetch_t[OP_AT[i]];
        check($sformatf("clocks op %0d", i), 32'(k), 32'(3 * OP_MC[i]));
      end
      check("no fetch past halt", 32'(fetch_t[20]), 32'h0);
    end
    finish_test();
  end
endmodule
`default_nettype wire

//--- verilog/lgde_core.sv
// load group sequencer, register bank and wishbone register port
//
// The Wishbone interface to the registers and the register addresses were left to the implementer.
`default_nettype none
`timescale 1ns/1ns
`include "lgde_map.svh"
// Overview of operation
// (RULE1) halt and status ops match whole byte
// (RULE2) store r0-to-r0 code acts as no-op
// (RULE3) and r0-with-r0 code acts as halt
// (RULE4) register load copies into r0, two cycles
// (RULE5) software avoids byte 00, uses 60 instead
// (RULE6) immediate load writes second byte, two cycles
// (RULE7) relative load from next-address plus displacement
// (RULE8) absolute load reads effective address, four cycles
// (RULE9) indexed absolute load targets register zero
// (RULE10) flags follow loaded value sign and zero
// (RULE11) bits 7..2 select group, 1..0 register
// (RULE12) seven-bit signed displacement, top bit indirect
// (RULE13) index control: none, pre-inc, pre-dec, plain
// (RULE14) indirection adds two cycles, one level
// (RULE15) pointer is fifteen bits, index added after
module lgde_core
  import lgde_pkg::*;
#(
  parameter int NUM_REGS = 4
) (
  input  wire logic        clk_sys_in,
  input  wire logic        nrst_in,
  input  wire logic        ce_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [31:0] wb_dat_in,
  output logic [31:0]      wb_dat_out,
  input  wire logic        wb_we_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  output logic             wb_ack_out,
  output logic [14:0]      mem_addr_out,
  output logic             mem_rd_out,
  input  wire logic [7:0]  mem_data_in
);

  // the register field is two bits wide, so exactly four registers
  if (NUM_REGS != 4) begin : g_bad_regs
    $error("lgde_core: NUM_REGS must be 4");
  end

  lgde_state_t st_reg;           // sequencer state
  lgde_state_t st_next;
  logic [1:0]  ph_reg;           // clock phase inside machine cycle
  logic [3:0]  mc_cnt_reg;       // machine cycles of current instruction
  logic [14:0] pc_reg;           // next instruction byte
  logic [14:0] pc_next;
  logic [14:0] addr_reg;         // memory address pins
  logic [14:0] addr_next;
  logic        rd_reg;           // memory read strobe
  logic        rd_next;
  logic [7:0]  op_reg;           // first byte
  logic [7:0]  b1_reg;           // second byte
  logic [7:0]  ptr_hi_reg;       // upper pointer byte
  logic [14:0] ea_reg;           // pointer or operand address
  logic [14:0] ea_next;
  logic [7:0]  regs_reg [4];     // general registers r0..r3
  logic [1:0]  cc_reg;           // condition flags
  logic        run_en_reg;       // software run enable
  logic        ack_reg;          // bus acknowledge
  logic [31:0] rdat_reg;         // bus read data
  logic        reg_we;           // engine register write
  logic [1:0]  reg_idx;
  logic [7:0]  reg_val;
  logic        load_wr;          // register write that sets flags
  logic        instr_done;
  logic [14:0] ea_base;
  logic [7:0]  ea_off;
  logic        ea_sign;
  logic [14:0] ea_sum;
  lgde_kind_t  dec_kind;
  logic [1:0]  dec_sel;

  // first byte comes straight from memory during its own fetch
  wire [7:0]  dec_op   = (st_reg == ST_FETCH0) ? mem_data_in : op_reg;
  wire        running  = (st_reg != ST_IDLE) && (st_reg != ST_HALTED);
  wire        mc_end   = (ph_reg == `LGDE_PH_LAST);
  wire        adv      = ce_in & (mc_end | ~running);
  wire        reg_we_g = reg_we & adv;
  wire        load_g   = load_wr & adv;
  wire        done_g   = instr_done & adv;
  wire [14:0] pc_inc   = {pc_reg[14:13], pc_reg[12:0] + 13'h0001};
  wire [1:0]  ic_now   = (st_reg == ST_FETCH1) ? mem_data_in[6:5]
                                               : b1_reg[6:5];
  // (RULE13) any nonzero index control means indexed
  wire        idx_en   = (dec_kind == K_LOAD_ABS) && (ic_now != `LGDE_IC_NONE);
  wire [7:0]  idx_val  = regs_reg[dec_sel];
  wire [1:0]  cc_of    = (reg_val == 8'h00) ? `LGDE_CC_ZERO :
                         reg_val[7] ? `LGDE_CC_NEG : `LGDE_CC_POS;

  // bus decode
  wire [7:0]  adr_w    = {wb_adr_in[7:2], 2'b00};
  wire        hit_ctrl = (adr_w == `LGDE_OFF_CTRL);
  wire        hit_stat = (adr_w == `LGDE_OFF_STAT);
  wire        hit_pc   = (adr_w == `LGDE_OFF_PC);
  wire        hit_reg  = (adr_w[7:4] == 4'(`LGDE_OFF_REGS >> 4));
  wire        bus_req  = wb_cyc_in & wb_stb_in;
  // writes land on the edge where ack is seen
  wire        bus_wr   = bus_req & wb_we_in & ack_reg;
  wire        resume_wr = bus_wr & hit_ctrl & wb_sel_in[0]
                          & wb_dat_in[`LGDE_CTRL_RESUME];
  // program state only writable while the engine is stopped
  wire        bus_pc_wr  = bus_wr & hit_pc & ~running;
  wire        bus_reg_wr = bus_wr & hit_reg & wb_sel_in[0] & ~running;
  wire [31:0] rd_ctrl  = {31'h0, run_en_reg};
  wire [31:0] rd_stat  = {28'h0, cc_reg, running, st_reg == ST_HALTED};
  wire [31:0] rd_pc    = {17'h0, pc_reg};
  wire [31:0] rd_regs  = {24'h0, regs_reg[wb_adr_in[3:2]]};
  // unmapped offsets read zero
  wire [31:0] rd_mux   = ({32{hit_ctrl}} & rd_ctrl) | ({32{hit_stat}} & rd_stat)
                       | ({32{hit_pc}} & rd_pc) | ({32{hit_reg}} & rd_regs);

  lgde_decode u_decode (
    .op_in    (dec_op),
    .kind_out (dec_kind),
    .sel_out  (dec_sel)
  );

  lgde_ea_calc u_ea (
    .base_in (ea_base),
    .off_in  (ea_off),
    .sign_in (ea_sign),
    .ea_out  (ea_sum)
  );

  // next-state, address and write selection for one machine cycle
  always_comb begin
    st_next    = st_reg;
    pc_next    = pc_reg;
    addr_next  = addr_reg;
    rd_next    = rd_reg;
    ea_next    = ea_reg;
    reg_we     = 1'b0;
    load_wr    = 1'b0;
    reg_idx    = dec_sel;
    reg_val    = mem_data_in;
    instr_done = 1'b0;
    // (RULE12) signed seven-bit displacement
    ea_base    = pc_inc;
    ea_off     = {mem_data_in[6], mem_data_in[6:0]};
    ea_sign    = 1'b1;
    unique case (st_reg)
      ST_IDLE: begin
        if (run_en_reg) begin
          st_next   = ST_FETCH0;
          addr_next = pc_reg;
          rd_next   = 1'b1;
        end
      end
      ST_HALTED: begin
        // leaves only on a software resume
        if (resume_wr) begin
          st_next = ST_IDLE;
        end
      end
      ST_FETCH0: begin
        pc_next   = pc_inc;
        addr_next = pc_inc;
        if ((dec_kind == K_LOAD_IMM) || (dec_kind == K_LOAD_REL) ||
            (dec_kind == K_LOAD_ABS) || (dec_kind == K_STATUS)) begin
          st_next = ST_FETCH1;
        end else begin
          st_next = ST_EXEC;
          rd_next = 1'b0;
        end
      end
      ST_FETCH1: begin
        pc_next   = pc_inc;
        addr_next = pc_inc;
        if (dec_kind == K_LOAD_IMM) begin
          // (RULE6) second byte into register
          reg_we     = 1'b1;
          load_wr    = 1'b1;
          instr_done = 1'b1;
        end else if (dec_kind == K_LOAD_REL) begin
          // (RULE7) next address plus displacement
          ea_next   = ea_sum;
          addr_next = ea_sum;
          // (RULE12) top bit asks for indirection
          st_next   = mem_data_in[7] ? ST_IND_HI : ST_DATA;
        end else if (dec_kind == K_LOAD_ABS) begin
          st_next = ST_FETCH2;
          // (RULE13) pre-increment or pre-decrement index
          if (idx_en && (ic_now != 2'h3)) begin
            reg_we  = 1'b1;
            reg_val = (ic_now == `LGDE_IC_INC) ? idx_val + 8'h01
                                               : idx_val - 8'h01;
          end
        end else begin
          // status ops: mask byte fetched, no effect here
          instr_done = 1'b1;
        end
      end
      ST_FETCH2: begin
        pc_next = pc_inc;
        ea_base = {pc_reg[14:13], b1_reg[4:0], mem_data_in};
        ea_off  = idx_en ? idx_val : 8'h00;
        ea_sign = 1'b0;
        // (RULE15) index waits until the pointer is fetched
        if (b1_reg[7]) begin
          ea_next   = ea_base;
          addr_next = ea_base;
          st_next   = ST_IND_HI;
        end else begin
          // (RULE8) indexed or plain operand address
          ea_next   = ea_sum;
          addr_next = ea_sum;
          st_next   = ST_DATA;
        end
      end
      ST_IND_HI: begin
        // (RULE14) single level, two extra cycles
        addr_next = ea_reg + 15'h0001;
        st_next   = ST_IND_LO;
      end
      ST_IND_LO: begin
        // (RULE15) top pointer bit dropped, index added
        ea_base   = {ptr_hi_reg[6:0], mem_data_in};
        ea_off    = idx_en ? idx_val : 8'h00;
        ea_sign   = 1'b0;
        ea_next   = ea_sum;
        addr_next = ea_sum;
        st_next   = ST_DATA;
      end
      ST_DATA: begin
        // (RULE9) indexed absolute loads land in r0
        reg_idx    = idx_en ? 2'h0 : dec_sel;
        reg_we     = 1'b1;
        load_wr    = 1'b1;
        instr_done = 1'b1;
      end
      ST_EXEC: begin
        instr_done = 1'b1;
        // (RULE4) register copied into r0
        if ((dec_kind == K_LOAD_REG) || (dec_kind == K_R0_ALIAS)) begin
          reg_idx = 2'h0;
          reg_val = (dec_kind == K_R0_ALIAS) ? regs_reg[0] : idx_val;
          reg_we  = 1'b1;
          load_wr = 1'b1;
        end
      end
      default: begin
        st_next = ST_IDLE;
        rd_next = 1'b0;
      end
    endcase
    if (instr_done) begin
      addr_next = pc_next;
      // (RULE3) halt code stops the sequencer
      if (dec_kind == K_HALT) begin
        st_next = ST_HALTED;
        rd_next = 1'b0;
      end else begin
        st_next = run_en_reg ? ST_FETCH0 : ST_IDLE;
        rd_next = run_en_reg;
      end
    end
  end

  // sequencer and address registers
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      st_reg   <= ST_IDLE;
      ph_reg   <= 2'h0;
      addr_reg <= `LGDE_PC_RST;
      rd_reg   <= 1'b0;
      ea_reg   <= `LGDE_PC_RST;
    end else if (ce_in) begin
      ph_reg <= (mc_end | ~running) ? 2'h0 : ph_reg + 2'h1;
      if (adv) begin
        st_reg   <= st_next;
        addr_reg <= addr_next;
        rd_reg   <= rd_next;
        ea_reg   <= ea_next;
      end
    end
  end

  // instruction bytes captured at the end of their fetch
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      op_reg     <= 8'h00;
      b1_reg     <= 8'h00;
      ptr_hi_reg <= 8'h00;
    end else if (adv) begin
      if (st_reg == ST_FETCH0) op_reg <= mem_data_in;
      if (st_reg == ST_FETCH1) b1_reg <= mem_data_in;
      if (st_reg == ST_IND_HI) ptr_hi_reg <= mem_data_in;
    end
  end

  // program counter, flags and machine cycle count
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      pc_reg     <= `LGDE_PC_RST;
      cc_reg     <= `LGDE_CC_RST;
      mc_cnt_reg <= 4'h0;
    end else if (ce_in) begin
      if (bus_pc_wr) begin
        pc_reg <= {wb_sel_in[1] ? wb_dat_in[14:8] : pc_reg[14:8],
                   wb_sel_in[0] ? wb_dat_in[7:0] : pc_reg[7:0]};
      end else if (adv) begin
        pc_reg <= pc_next;
      end
      // (RULE10) flags from the loaded value
      if (load_g) cc_reg <= cc_of;
      if (adv && running) mc_cnt_reg <= instr_done ? 4'h0 : mc_cnt_reg + 4'h1;
    end
  end

  // register bank, one process per entry; engine and bus never overlap
  for (genvar i = 0; i < 4; i++) begin : g_regs
    always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
        regs_reg[i] <= `LGDE_REG_RST;
      end else if (ce_in) begin
        if (reg_we_g && (reg_idx == 2'(i))) begin
          regs_reg[i] <= reg_val;
        end else if (bus_reg_wr && (wb_adr_in[3:2] == 2'(i))) begin
          regs_reg[i] <= wb_dat_in[7:0];
        end
      end
    end
  end

  // wishbone slave: one wait state, ack drops after one cycle
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      ack_reg    <= 1'b0;
      rdat_reg   <= 32'h0000_0000;
      run_en_reg <= 1'b0;
    end else if (ce_in) begin
      ack_reg <= bus_req & ~ack_reg;
      if (bus_req & ~ack_reg) rdat_reg <= rd_mux;
      if (bus_wr & hit_ctrl & wb_sel_in[0]) begin
        run_en_reg <= wb_dat_in[`LGDE_CTRL_RUN];
      end
    end
  end

  assign wb_ack_out   = ack_reg;
  assign wb_dat_out   = rdat_reg;
  assign mem_addr_out = addr_reg;
  assign mem_rd_out   = rd_reg;

  // checks on the sequencer
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  AST_FULL_BYTE_HALT: assert property ( // RULE1
    (dec_kind == K_HALT) |-> (dec_op == `LGDE_OP_HALT))
    else $error("halt decoded from a partial byte");
  AST_NOP_NO_WRITE: assert property ( // RULE2
    (st_reg == ST_EXEC && dec_kind == K_NOP) |-> !reg_we)
    else $error("no-op wrote a register");
  AST_HALT_STOPS: assert property ( // RULE3
    (st_reg == ST_EXEC && dec_kind == K_HALT && adv)
      |=> (st_reg == ST_HALTED && regs_reg[0] == $past(regs_reg[0])))
    else $error("halt code did not halt");
  AST_REG_LOAD: assert property ( // RULE4
    (done_g && dec_kind == K_LOAD_REG)
      |-> (mc_cnt_reg == `LGDE_MC_REG - 4'h1)
      ##1 (regs_reg[0] == $past(idx_val)))
    else $error("register load wrong value or time");
  AST_IMM_TIME: assert property ( // RULE6
    (done_g && dec_kind == K_LOAD_IMM) |-> mc_cnt_reg == `LGDE_MC_IMM - 4'h1)
    else $error("immediate load took wrong cycle count");
  AST_REL_TIME: assert property ( // RULE7
    (done_g && dec_kind == K_LOAD_REL) |-> mc_cnt_reg ==
      `LGDE_MC_REL - 4'h1 + (b1_reg[7] ? `LGDE_MC_IND : 4'h0))
    else $error("relative load took wrong cycle count");
  AST_ABS_TIME: assert property ( // RULE8
    (done_g && dec_kind == K_LOAD_ABS) |-> mc_cnt_reg ==
      `LGDE_MC_ABS - 4'h1 + (b1_reg[7] ? `LGDE_MC_IND : 4'h0))
    else $error("absolute load took wrong cycle count");
  AST_IDX_TO_R0: assert property ( // RULE9
    (load_g && dec_kind == K_LOAD_ABS && b1_reg[6:5] != `LGDE_IC_NONE)
      |-> reg_idx == 2'h0)
    else $error("indexed load not aimed at r0");
  AST_FLAGS: assert property ( // RULE10
    load_g |=> cc_reg == ($past(reg_val) == 8'h00 ? `LGDE_CC_ZERO :
                          ($past(reg_val) > 8'h7f) ? `LGDE_CC_NEG :
                          `LGDE_CC_POS))
    else $error("flags do not match loaded value");
  AST_IND_PAIR: assert property ( // RULE14
    (st_reg == ST_IND_HI && adv) |=> st_reg == ST_IND_LO
      && addr_reg == $past(ea_reg) + 15'h0001)
    else $error("pointer bytes not read as a pair");

endmodule
`default_nettype wire

//--- verilog/lgde_decode.sv
// first-byte decoder of the load group
`default_nettype none
`timescale 1ns/1ns
`include "lgde_map.svh"
module lgde_decode
  import lgde_pkg::*;
(
  input  wire logic [7:0] op_in,
  output lgde_kind_t      kind_out,
  output logic [1:0]      sel_out
);

  // whole-byte matches; these take priority over group fields
  wire is_halt   = (op_in == `LGDE_OP_HALT);
  // (RULE2) store r0-to-r0 code decodes as no-op
  wire is_nop    = (op_in == `LGDE_OP_NOP);
  wire is_alias  = (op_in == `LGDE_OP_R0_ALIAS);
  wire is_status = (op_in == `LGDE_OP_CLR_UPPER) |
                   (op_in == `LGDE_OP_CLR_LOWER);
  wire [5:0] grp = op_in[7:2];

  // (RULE11) register field always bits 1..0
  assign sel_out = op_in[1:0];

  // kind selection, full-byte codes first
  always_comb begin
    // (RULE1) whole byte compare
    if (is_halt) begin
      kind_out = K_HALT;
    end else if (is_nop) begin
      kind_out = K_NOP;
    end else if (is_alias) begin
      kind_out = K_R0_ALIAS;
    end else if (is_status) begin
      kind_out = K_STATUS;
    end else begin
      // (RULE11) group from bits 7..2
      unique case (grp)
        `LGDE_GRP_REG: kind_out = K_LOAD_REG;
        `LGDE_GRP_IMM: kind_out = K_LOAD_IMM;
        `LGDE_GRP_REL: kind_out = K_LOAD_REL;
        `LGDE_GRP_ABS: kind_out = K_LOAD_ABS;
        default:       kind_out = K_OTHER;
      endcase
    end
  end

endmodule
`default_nettype wire

//--- verilog/lgde_ea_calc.sv
// page-wrapped effective address adder
`default_nettype none
`timescale 1ns/1ns
module lgde_ea_calc (
  input  wire logic [14:0] base_in,
  input  wire logic [7:0]  off_in,
  input  wire logic        sign_in,
  output logic [14:0]      ea_out
);

  // offset widened; sign only for relative displacements
  wire [12:0] off_ext = {{5{sign_in & off_in[7]}}, off_in};
  // add stays inside the 8 KiB page, page bits pass through
  wire [12:0] low_sum = base_in[12:0] + off_ext;

  assign ea_out = {base_in[14:13], low_sum};

endmodule
`default_nettype wire

//--- verilog/lgde_map.svh
// offsets, fields, reset values, opcodes and cycle counts of the load unit
`ifndef LGDE_MAP_SVH
`define LGDE_MAP_SVH

// register byte offsets on the wishbone port
`define LGDE_OFF_CTRL      8'h00
`define LGDE_OFF_STAT      8'h04
`define LGDE_OFF_PC        8'h08
`define LGDE_OFF_REGS      8'h10

// control and status field positions
`define LGDE_CTRL_RUN      0
`define LGDE_CTRL_RESUME   1
`define LGDE_STAT_HALT     0
`define LGDE_STAT_BUSY     1
`define LGDE_STAT_CC_LO    2

// reset values
`define LGDE_PC_RST        15'h0000
`define LGDE_REG_RST       8'h00
`define LGDE_CC_RST        2'h0

// whole-byte opcodes and group codes (first byte bits 7..2)
`define LGDE_OP_HALT       8'h40
`define LGDE_OP_NOP        8'hc0
`define LGDE_OP_CLR_UPPER  8'h74
`define LGDE_OP_CLR_LOWER  8'h75
`define LGDE_OP_R0_ALIAS   8'h60
`define LGDE_GRP_REG       6'h00
`define LGDE_GRP_IMM       6'h01
`define LGDE_GRP_REL       6'h02
`define LGDE_GRP_ABS       6'h03

// index control codes
`define LGDE_IC_NONE       2'h0
`define LGDE_IC_INC        2'h1
`define LGDE_IC_DEC        2'h2

// condition flag codes
`define LGDE_CC_ZERO       2'h0
`define LGDE_CC_POS        2'h1
`define LGDE_CC_NEG        2'h2

// clock periods per machine cycle, last phase index
`define LGDE_CLK_PER_MC    3
`define LGDE_PH_LAST       2'h2

// machine cycles per instruction
`define LGDE_MC_REG        4'h2
`define LGDE_MC_IMM        4'h2
`define LGDE_MC_REL        4'h3
`define LGDE_MC_ABS        4'h4
`define LGDE_MC_IND        4'h2

`endif

//--- verilog/lgde_pkg.sv
// types shared by the load group decode and execute unit
`default_nettype none
package lgde_pkg;

  // sequencer states, one machine cycle each apart from idle and halted
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0000,
    ST_FETCH0 = 4'b0001,
    ST_FETCH1 = 4'b0010,
    ST_FETCH2 = 4'b0011,
    ST_IND_HI = 4'b0100,
    ST_IND_LO = 4'b0101,
    ST_DATA   = 4'b0110,
    ST_EXEC   = 4'b0111,
    ST_HALTED = 4'b1000
  } lgde_state_t;

  // decoded instruction kinds
  typedef enum logic [3:0] {
    K_LOAD_REG    = 4'b0000,
    K_LOAD_IMM    = 4'b0001,
    K_LOAD_REL    = 4'b0010,
    K_LOAD_ABS    = 4'b0011,
    K_NOP         = 4'b0100,
    K_HALT        = 4'b0101,
    K_R0_ALIAS    = 4'b0110,
    K_STATUS      = 4'b0111,
    K_OTHER       = 4'b1000
  } lgde_kind_t;

endpackage
`default_nettype wire
